// [bench/otp_model.sv]
`timescale 1ns/1ns
module otp_model #(
	parameter [2:0] CFG = 3'h6
) (
	input wire clk,
	input wire rst_n,
	input wire otp_reload,
	output wire [2:0] otp_out_cfg,
	output wire otp_valid
);
	reg [1:0] wait_r;
	// Fuse sensing is slow, so data lags each request
	always @(posedge clk or negedge rst_n) begin
		if (!rst_n)
			wait_r <= 2'h3;
		else if (otp_reload)
			wait_r <= 2'h3;
		else if (wait_r != 2'h0)
			wait_r <= wait_r - 2'h1;
	end
	assign otp_valid = wait_r == 2'h0;
	// Unsettled fuses show the inverse pattern
	assign otp_out_cfg = otp_valid ? CFG : ~CFG;
endmodule // otp_model

// [bench/test_wdog_top_regs.sv]
`timescale 1ns/1ns
module test_wdog_top_regs;
	reg clk, rst_n, reg_wr, reg_rd, watchdog_config_lock, wd_reset_pulse;
	reg restart_flag_blocking_mode, current_result_event, sync_clk_valid;
	reg thermal_shutdown_live, thermal_warning_live, overvoltage_live;
	reg [7:0] reg_addr, reg_wdata, diagnostic_interrupt_reg;
	reg [7:0] boost_interrupt_reg, stepdown_interrupt_reg;
	reg [1:0] pulse_counter_threshold;
	wire [7:0] reg_rdata;
	wire [2:0] otp_out_cfg;
	wire otp_valid, otp_reload, restart_request, converters_blocked;
	wire thermal_warning_clear, trigger_pulldown_select, registers_reset;
	wire reset_out_polarity, reset_out_drive_type;
	wire [7:0] cfg = {5'h0, trigger_pulldown_select, reset_out_polarity,
		reset_out_drive_type};
	integer n_errors, checked, cyc, n_rr, i;
	wdog_top_regs i_dut (.*);
	otp_model i_otp (.*);
	// ----------------------------------------
	// Bus and check tasks
	// ----------------------------------------
	task chk(input [7:0] seen, input [7:0] exp, input [63:0] what);
		begin
			checked = checked + 1;
			if (seen !== exp) begin
				n_errors = n_errors + 1;
				$display("mismatch %0s exp %h seen %h", what, exp, seen);
			end
		end
	endtask
	task wr(input [7:0] a, input [7:0] d);
		begin
			@(posedge clk) reg_wr <= 1'b1;
			reg_addr <= a;
			reg_wdata <= d;
			@(posedge clk) reg_wr <= 1'b0;
		end
	endtask
	task rd(input [7:0] a, input [7:0] e);
		begin
			@(posedge clk) reg_rd <= 1'b1;
			reg_addr <= a;
			@(posedge clk) reg_rd <= 1'b0;
			#1 chk(reg_rdata, e, "rdata");
		end
	endtask
	task wd(input integer n);
		repeat (n) begin
			@(posedge clk) wd_reset_pulse <= 1'b1;
			@(posedge clk) wd_reset_pulse <= 1'b0;
		end
	endtask
	task report_and_stop;
		begin
			if (n_errors == 0 && checked > 0)
				$display("SIMULATION PASSED");
			else
				$display("SIMULATION FAILED");
			$finish;
		end
	endtask
	initial begin
		clk = 0;
		forever #5 clk = ~clk;
	end
	// Hang guard, also tallies restart pulses
	always @(posedge clk) begin
		cyc = cyc + 1;
		if (restart_request === 1'b1)
			n_rr = n_rr + 1;
		if (cyc == 3000) begin
			n_errors = n_errors + 1;
			report_and_stop;
		end
	end
	initial begin
		{rst_n, reg_wr, reg_rd, watchdog_config_lock, wd_reset_pulse} = 0;
		{restart_flag_blocking_mode, current_result_event} = 0;
		{sync_clk_valid, thermal_shutdown_live, thermal_warning_live} = 0;
		{overvoltage_live, pulse_counter_threshold, reg_addr} = 0;
		{reg_wdata, diagnostic_interrupt_reg, boost_interrupt_reg} = 0;
		stepdown_interrupt_reg = 0;
		{n_errors, checked, cyc, n_rr} = 0;
		repeat (2) @(posedge clk);
		chk(cfg, 8'h01, "cfg");
		rst_n <= 1'b1;
		repeat (6) @(posedge clk);
		#1 chk(cfg, 8'h06, "cfg");
		wr(8'h1D, 8'h05);
		#1 chk(cfg, 8'h05, "cfg");
		wr(8'h1D, 8'h02);
		#1 chk(cfg, 8'h02, "cfg");
		@(posedge clk) watchdog_config_lock <= 1'b1;
		wd(3);
		rd(8'h1E, 8'h03);
		wr(8'h1E, 8'h04);
		rd(8'h1E, 8'h00);
		for (i = 1; i < 4; i = i + 1) begin
			@(posedge clk) pulse_counter_threshold <= i[1:0];
			wd((i == 3) ? 3 : i - 1);
			rd(8'h1E, (i == 3) ? 8'h03 : i[7:0] - 8'h01);
			wd(1);
			rd(8'h1E, 8'h08);
			wr(8'h1E, 8'h10);
			rd(8'h1E, 8'h00);
		end
		@(posedge clk) restart_flag_blocking_mode <= 1'b1;
		pulse_counter_threshold <= 2'h1;
		wd(3);
		rd(8'h1E, 8'h08);
		chk(n_rr[7:0], 8'h04, "restarts");
		@(posedge clk) current_result_event <= 1'b1;
		@(posedge clk) current_result_event <= 1'b0;
		{sync_clk_valid, thermal_warning_live, overvoltage_live} <= 3'h7;
		rd(8'h20, 8'h8B);
		wr(8'h20, 8'h81);
		rd(8'h20, 8'h0A);
		wr(8'h20, 8'h0A);
		rd(8'h20, 8'h00);
		@(posedge clk) diagnostic_interrupt_reg <= 8'h01;
		rd(8'h20, 8'h40);
		@(posedge clk) boost_interrupt_reg <= 8'h04;
		rd(8'h20, 8'h60);
		@(posedge clk) stepdown_interrupt_reg <= 8'h80;
		rd(8'h20, 8'h70);
		@(posedge clk) diagnostic_interrupt_reg <= 8'h00;
		{boost_interrupt_reg, stepdown_interrupt_reg} <= 16'h0;
		rd(8'h20, 8'h00);
		@(posedge clk) thermal_warning_live <= 1'b0;
		@(posedge clk) thermal_warning_live <= 1'b1;
		thermal_shutdown_live <= 1'b1;
		rd(8'h20, 8'h06);
		chk({7'h0, converters_blocked}, 8'h01, "blocked");
		wr(8'h20, 8'h04);
		rd(8'h20, 8'h00);
		chk({7'h0, converters_blocked}, 8'h00, "blocked");
		@(posedge clk) watchdog_config_lock <= 1'b0;
		wr(8'h1D, 8'h00);
		@(posedge clk) sync_clk_valid <= 1'b0;
		{thermal_shutdown_live, thermal_warning_live} <= 2'h0;
		overvoltage_live <= 1'b0;
		rd(8'h20, 8'h08);
		wr(8'h1F, 8'h01);
		rd(8'h1F, 8'h00);
		rd(8'h20, 8'h00);
		repeat (6) @(posedge clk);
		#1 chk(cfg, 8'h06, "cfg");
		report_and_stop;
	end
endmodule // test_wdog_top_regs

// [bench/wdog_top_regs_sva.sv]
`timescale 1ns/1ns
module wdog_top_regs_sva (
	input wire clk,
	input wire rst_n,
	input wire reg_wr,
	input wire reg_rd,
	input wire [7:0] reg_addr,
	input wire [7:0] reg_wdata,
	input wire [7:0] reg_rdata,
	input wire otp_valid,
	input wire watchdog_config_lock,
	input wire [1:0] pulse_counter_threshold,
	input wire wd_reset_pulse,
	input wire restart_request,
	input wire [7:0] diagnostic_interrupt_reg,
	input wire [7:0] stepdown_interrupt_reg,
	input wire thermal_shutdown_live,
	input wire converters_blocked,
	input wire thermal_warning_clear,
	input wire trigger_pulldown_select,
	input wire reset_out_polarity,
	input wire reset_out_drive_type,
	input wire registers_reset
);
	default clocking @(posedge clk); endclocking
	default disable iff (!rst_n);
	wire [2:0] cfg = {trigger_pulldown_select, reset_out_polarity,
		reset_out_drive_type};
	wire rd_top = reg_rd && reg_addr == 8'h20;
	property p_cfg;
		reg_wr && reg_addr == 8'h1D && otp_valid && $past(otp_valid) &&
		!watchdog_config_lock && !registers_reset
		|=> cfg == $past(reg_wdata[2:0]);
	endproperty
	a_cfg: assert property (p_cfg) else $error("cfg write lost");
	property p_rr;
		restart_request |-> $past(wd_reset_pulse);
	endproperty
	a_rr: assert property (p_rr) else $error("restart uncaused");
	property p_off;
		pulse_counter_threshold == 2'h0 &&
		$past(pulse_counter_threshold) == 2'h0 |-> !restart_request;
	endproperty
	a_off: assert property (p_off) else $error("restart when off");
	property p_tsd;
		$rose(thermal_shutdown_live) |-> ##[1:3] converters_blocked;
	endproperty
	a_tsd: assert property (p_tsd) else $error("no block");
	property p_twc;
		thermal_warning_clear |-> ##[0:1] !converters_blocked;
	endproperty
	a_twc: assert property (p_twc) else $error("still blocked");
	property p_diag;
		rd_top && $stable(diagnostic_interrupt_reg)
		|=> reg_rdata[6] == $past(|diagnostic_interrupt_reg);
	endproperty
	a_diag: assert property (p_diag) else $error("diag bit");
	property p_step;
		rd_top && $stable(stepdown_interrupt_reg)
		|=> reg_rdata[4] == $past(|stepdown_interrupt_reg);
	endproperty
	a_step: assert property (p_step) else $error("stepdown bit");
	property p_swr;
		reg_wr && reg_addr == 8'h1F && reg_wdata[0]
		|-> ##[1:2] registers_reset;
	endproperty
	a_swr: assert property (p_swr) else $error("no soft reset");
endmodule // wdog_top_regs_sva
bind wdog_top_regs wdog_top_regs_sva i_sva (.*);

// [pkg/wdog_top_defs.vh]
`ifndef WDOG_TOP_DEFS_VH
`define WDOG_TOP_DEFS_VH

// ----------------------------------------
// Register offsets
// ----------------------------------------
`define OFS_WD_OUT_CFG 8'h1D
`define OFS_WATCHDOG_STATUS 8'h1E
`define OFS_SOFT_RESET 8'h1F
`define OFS_TOP_INT 8'h20

// ----------------------------------------
// Field positions
// ----------------------------------------
`define CFG_PULLDOWN_BIT 2
`define CFG_POLARITY_BIT 1
`define CFG_DRIVE_BIT 0
`define ST_FLAG_CLR_BIT 4
`define ST_FLAG_BIT 3
`define ST_CNT_CLR_BIT 2
`define SWRST_BIT 0
`define TI_CURRENT_BIT 7
`define TI_DIAG_BIT 6
`define TI_BOOST_BIT 5
`define TI_STEPDOWN_BIT 4
`define TI_SYNC_BIT 3
`define TI_TSD_BIT 2
`define TI_TWARN_BIT 1
`define TI_OVP_BIT 0

// ----------------------------------------
// Threshold encodings
// ----------------------------------------
`define THR_OFF 2'h0
`define THR_ONE 2'h1
`define THR_TWO 2'h2
`define THR_FOUR 2'h3

`endif

// [verilog/wdog_top_regs.v]
`timescale 1ns/1ns
// Operation
// - Config bit 2 enables trigger pull-down
// - Config bit 1 sets reset polarity low
// - Config bit 0 open-drain, resets to one
// - Config defaults come from OTP memory
// - Status bit 4 pulses restart flag clear
// - Status bit 3 holds restart occurred
// - Status bit 2 clears pulse counter
// - Status bits 1-0 show pulse count
// - Software reset restores defaults, rereads OTP
// - Bit 7 latches current result, W1C
// - Bit 6 follows diagnostic register nonzero
// - Bit 5 follows boost register nonzero
// - Bit 4 follows step-down register nonzero
// - Bit 3 latches sync validity change, W1C
// - Bit 2 thermal shutdown blocks converters, W1C
// - Clearing shutdown re-enables, clears warning
// - Bit 1 latches thermal warning, W1C
// - Bit 0 latches overvoltage, W1C
// - Lock never blocks status clears
// - Threshold restarts after 1,2,4 pulses
// - Blocking mode flag stops further restarts

module wdog_top_regs (
	input wire clk,
	input wire rst_n,
	input wire reg_wr,
	input wire reg_rd,
	input wire [7:0] reg_addr,
	input wire [7:0] reg_wdata,
	output reg [7:0] reg_rdata,
	input wire [2:0] otp_out_cfg,
	input wire otp_valid,
	output wire otp_reload,
	input wire watchdog_config_lock,
	input wire [1:0] pulse_counter_threshold,
	input wire restart_flag_blocking_mode,
	input wire wd_reset_pulse,
	output reg restart_request,
	input wire [7:0] diagnostic_interrupt_reg,
	input wire [7:0] boost_interrupt_reg,
	input wire [7:0] stepdown_interrupt_reg,
	input wire current_result_event,
	input wire sync_clk_valid,
	input wire thermal_shutdown_live,
	input wire thermal_warning_live,
	input wire overvoltage_live,
	output wire converters_blocked,
	output reg thermal_warning_clear,
	output wire trigger_pulldown_select,
	output wire reset_out_polarity,
	output wire reset_out_drive_type,
	output wire registers_reset
);

`include "wdog_top_defs.vh"

// ----------------------------------------
// Decode helpers
// ----------------------------------------
function hit;
	input [7:0] a;
	input [7:0] ofs;
	begin
		hit = (a == ofs);
	end
endfunction

function [2:0] thr_count;
	input [1:0] sel;
	begin
		case (sel)
			`THR_ONE: thr_count = 3'h1;
			`THR_TWO: thr_count = 3'h2;
			`THR_FOUR: thr_count = 3'h4;
			default: thr_count = 3'h0;
		endcase
	end
endfunction

wire wr_cfg = reg_wr && hit(reg_addr, `OFS_WD_OUT_CFG);
wire wr_st = reg_wr && hit(reg_addr, `OFS_WATCHDOG_STATUS);
wire wr_rst = reg_wr && hit(reg_addr, `OFS_SOFT_RESET);
wire wr_ti = reg_wr && hit(reg_addr, `OFS_TOP_INT);

// ----------------------------------------
// Software reset sequencing
// ----------------------------------------
reg swrst_r;
reg reload_pend_r;
wire soft_rst = swrst_r;

always @(posedge clk or negedge rst_n) begin
	if (!rst_n) begin
		swrst_r <= 1'b0;
	end else begin
		// Request held one cycle, then drops by itself
		swrst_r <= wr_rst && reg_wdata[`SWRST_BIT];
	end
end

assign registers_reset = swrst_r;
assign otp_reload = swrst_r;

// ----------------------------------------
// Output configuration
// ----------------------------------------
reg [2:0] cfg_r;

always @(posedge clk or negedge rst_n) begin
	if (!rst_n) begin
		cfg_r <= 3'h1;
		reload_pend_r <= 1'b1;
	end else if (soft_rst) begin
		cfg_r <= 3'h1;
		reload_pend_r <= 1'b1;
	end else if (reload_pend_r && otp_valid) begin
		// OTP image wins over the reset constant
		cfg_r <= otp_out_cfg;
		reload_pend_r <= 1'b0;
	end else if (wr_cfg && !watchdog_config_lock) begin
		cfg_r <= reg_wdata[2:0];
	end
end

assign trigger_pulldown_select = cfg_r[`CFG_PULLDOWN_BIT];
assign reset_out_polarity = cfg_r[`CFG_POLARITY_BIT];
assign reset_out_drive_type = cfg_r[`CFG_DRIVE_BIT];

// ----------------------------------------
// Watchdog status
// ----------------------------------------
reg flag_r;
reg flag_clr_r;
reg cnt_clr_r;
reg [2:0] cnt_r;
wire [2:0] thr = thr_count(pulse_counter_threshold);
// Lock is deliberately not consulted here
wire flag_clr_req = wr_st && reg_wdata[`ST_FLAG_CLR_BIT];
wire cnt_clr_req = wr_st && reg_wdata[`ST_CNT_CLR_BIT];
wire restart_allowed = !(restart_flag_blocking_mode && flag_r);
wire cnt_at_thr = (thr != 3'h0) && ((cnt_r + 3'h1) >= thr);
wire restart_now = wd_reset_pulse && cnt_at_thr && restart_allowed;

always @(posedge clk or negedge rst_n) begin
	if (!rst_n) begin
		flag_r <= 1'b0;
		flag_clr_r <= 1'b0;
		cnt_clr_r <= 1'b0;
		cnt_r <= 3'h0;
		restart_request <= 1'b0;
	end else if (soft_rst) begin
		flag_r <= 1'b0;
		flag_clr_r <= 1'b0;
		cnt_clr_r <= 1'b0;
		cnt_r <= 3'h0;
		restart_request <= 1'b0;
	end else begin
		flag_clr_r <= flag_clr_req;
		cnt_clr_r <= cnt_clr_req;
		restart_request <= restart_now;
		// A restart in the clearing cycle keeps the flag
		if (restart_now)
			flag_r <= 1'b1;
		else if (flag_clr_r)
			flag_r <= 1'b0;
		if (restart_now)
			cnt_r <= 3'h0;
		// Counts only while restarts are allowed (not while blocked), also with threshold off
		else if (wd_reset_pulse && restart_allowed)
			cnt_r <= cnt_r + 3'h1;
		else if (cnt_clr_r)
			cnt_r <= 3'h0;
	end
end

// ----------------------------------------
// Top interrupt flags
// ----------------------------------------
reg current_r;
reg sync_r;
reg tsd_r;
reg twarn_r;
reg ovp_r;
reg sync_last_r;
reg tsd_last_r;
reg twarn_last_r;
reg ovp_last_r;
wire [7:0] w1c = wr_ti ? reg_wdata : 8'h00;
wire sync_chg = sync_clk_valid ^ sync_last_r;
wire tsd_rise = thermal_shutdown_live && !tsd_last_r;
wire twarn_rise = thermal_warning_live && !twarn_last_r;
wire ovp_rise = overvoltage_live && !ovp_last_r;

always @(posedge clk or negedge rst_n) begin
	if (!rst_n) begin
		current_r <= 1'b0;
		sync_r <= 1'b0;
		tsd_r <= 1'b0;
		twarn_r <= 1'b0;
		ovp_r <= 1'b0;
		sync_last_r <= 1'b0;
		tsd_last_r <= 1'b0;
		twarn_last_r <= 1'b0;
		ovp_last_r <= 1'b0;
		thermal_warning_clear <= 1'b0;
	end else begin
		sync_last_r <= sync_clk_valid;
		tsd_last_r <= thermal_shutdown_live;
		twarn_last_r <= thermal_warning_live;
		ovp_last_r <= overvoltage_live;
		// Clearing shutdown also drops the warning state
		thermal_warning_clear <= tsd_r && w1c[`TI_TSD_BIT] &&
			!tsd_rise && !soft_rst;
		if (soft_rst) begin
			current_r <= 1'b0;
			sync_r <= 1'b0;
			tsd_r <= 1'b0;
			twarn_r <= 1'b0;
			ovp_r <= 1'b0;
		end else begin
			// Set wins over a same-cycle write-one-clear
			current_r <= current_result_event ||
				(current_r && !w1c[`TI_CURRENT_BIT]);
			sync_r <= sync_chg ||
				(sync_r && !w1c[`TI_SYNC_BIT]);
			tsd_r <= tsd_rise ||
				(tsd_r && !w1c[`TI_TSD_BIT]);
			twarn_r <= twarn_rise || (twarn_r && !w1c[`TI_TWARN_BIT] &&
				!(tsd_r && w1c[`TI_TSD_BIT]));
			ovp_r <= ovp_rise ||
				(ovp_r && !w1c[`TI_OVP_BIT]);
		end
	end
end

// Shutdown flag itself gates enabling; clear lifts it
assign converters_blocked = tsd_r;

wire diag_sum = |diagnostic_interrupt_reg;
wire boost_sum = |boost_interrupt_reg;
wire step_sum = |stepdown_interrupt_reg;
wire [7:0] top_int = {current_r, diag_sum, boost_sum, step_sum,
	sync_r, tsd_r, twarn_r, ovp_r};
wire [7:0] status_val = {3'h0, flag_clr_r, flag_r, cnt_clr_r,
	cnt_r[1:0]};

// ----------------------------------------
// Read data
// ----------------------------------------
always @(posedge clk or negedge rst_n) begin
	if (!rst_n) begin
		reg_rdata <= 8'h00;
	end else if (reg_rd) begin
		if (hit(reg_addr, `OFS_WD_OUT_CFG))
			reg_rdata <= {5'h00, cfg_r};
		else if (hit(reg_addr, `OFS_WATCHDOG_STATUS))
			reg_rdata <= status_val;
		else if (hit(reg_addr, `OFS_SOFT_RESET))
			reg_rdata <= {7'h00, swrst_r};
		else if (hit(reg_addr, `OFS_TOP_INT))
			reg_rdata <= top_int;
		else
			reg_rdata <= 8'h00;
	end
end

endmodule // wdog_top_regs
